// ===== shared/sync_trigger_pkg.sv
// Shared constants for the sync-input trigger block
package sync_trigger_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DELAY_UNIT_US = 100;
  localparam int unsigned DELAY_UNIT_CYCLES = (CLK_HZ / 1_000_000) * DELAY_UNIT_US;
  localparam logic [15:0] DELAY_MAX = 16'hEA60;
  localparam logic [7:0] MSG_SYNC_CONFIG = 8'h2C;
  localparam int unsigned RECORD_BYTES = 12;
  localparam logic [3:0] OFS_ACTION = 4'h0;
  localparam logic [3:0] OFS_LINE = 4'h1;
  localparam logic [3:0] OFS_EDGE = 4'h2;
  localparam logic [3:0] OFS_SKIP_FIRST_LO = 4'h4;
  localparam logic [3:0] OFS_SKIP_FIRST_HI = 4'h5;
  localparam logic [3:0] OFS_SKIP_FACTOR_LO = 4'h6;
  localparam logic [3:0] OFS_SKIP_FACTOR_HI = 4'h7;
  localparam logic [3:0] OFS_DELAY_LO = 4'hA;
  localparam logic [3:0] OFS_DELAY_HI = 4'hB;
  localparam logic [7:0] ACTION_SEND_LATEST = 8'h08;
  localparam logic [7:0] LINE_SYNC_IN = 8'h02;
  localparam logic [7:0] EDGE_RISING = 8'h01;
  localparam logic [7:0] EDGE_FALLING = 8'h02;
  localparam logic [7:0] EDGE_BOTH = 8'h03;
  // Register map, word aligned byte addresses
  localparam logic [3:0] ADDR_MSG = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY} trig_state_t;
endpackage

// ===== core/sync_edge_detect.sv
// Pin synchroniser with edge detection on agreeing stages
`timescale 1ns/1ps
`default_nettype none
module sync_edge_detect (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Pin and edges
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  logic s1;
  logic s2;
  logic s3;
  logic level;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

  assign o_rise = (s2 == s3) && s3 && !level;
  assign o_fall = (s2 == s3) && !s3 && level;
endmodule
`default_nettype wire

// ===== core/sync_input_trigger.sv
// Sync-input trigger: configuration record intake and sync event qualification
// Contract
// R1 - Accepted sync pulse requests sending the latest data; estimation never stalls.
// R2 - Sync config message id 0x2C carries 12-byte setting records, applied.
// R3 - Byte 0 action code 8 sends latest; byte 1 line 2 selects sync in.
// R4 - Edge byte: 1 rising, 2 falling, 3 both edges.
// R5 - Skip the first N sync events, N from bytes 4-5.
// R6 - After each action skip M events, M from bytes 6-7.
// R7 - Delay bytes 10-11 in 100 us units, at most 60000, before acting.
// R8 - Bytes 3, 8 and 9 of a record are ignored.
`timescale 1ns/1ps
`default_nettype none
module sync_input_trigger
  import sync_trigger_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Sync pin
  input wire logic i_sync_in,
  // Output request to the data path
  output logic o_send_latest
);
  // Record intake
  logic [7:0] msg_id;
  logic [3:0] byte_idx;
  logic [7:0] rec_action;
  logic [7:0] rec_line;
  logic [7:0] rec_edge;
  logic [15:0] rec_skip_first;
  logic [15:0] rec_skip_factor;
  logic [15:0] rec_delay;
  // Active settings
  logic armed;
  logic [7:0] cfg_edge;
  logic [15:0] cfg_skip_factor;
  logic [15:0] cfg_delay;
  // Trigger state

  // Trigger state
  trig_state_t state;
  logic [15:0] skip_cnt;
  logic [15:0] units_left;
  logic [13:0] cyc_cnt;
  logic send_pulse;
  logic [15:0] action_count;
  logic [15:0] event_count;

  // Bus side
  logic ack;
  logic [31:0] rdata;

  function automatic logic [15:0] clamp_delay(input logic [15:0] v);
    clamp_delay = (v > DELAY_MAX) ? DELAY_MAX : v;
  endfunction

  // An edge counts when the configured edge code selects it
  function automatic logic edge_selected(input logic [7:0] code, input logic r, input logic f);
    edge_selected = (r && (code == EDGE_RISING || code == EDGE_BOTH)) ||
                    (f && (code == EDGE_FALLING || code == EDGE_BOTH));
  endfunction

  // Read data for a register address; unmapped addresses read zero
  function automatic logic [31:0] read_word(input logic [3:0] adr, input logic [7:0] id, input logic [3:0] idx,
                                            input logic [15:0] events, input logic [31:0] status);
    if (adr == ADDR_MSG) begin
      read_word = {24'h00_0000, id};
    end else if (adr == ADDR_DATA) begin
      read_word = {28'h000_0000, idx};
    end else if (adr == ADDR_CTRL) begin
      read_word = {16'h0000, events};
    end else if (adr == ADDR_STATUS) begin
      read_word = status;
    end else begin
      read_word = RESET_WORD;
    end
  endfunction

  // Bus decode
  // A pending ack blocks a second take of the same request
  wire req = i_wb_cyc && i_wb_stb && !ack;
  // Only byte lane 0 carries data; writes without it are dropped
  wire wr = req && i_wb_we && i_wb_sel[0];
  wire wr_msg = wr && (i_wb_adr == ADDR_MSG);
  wire wr_data = wr && (i_wb_adr == ADDR_DATA);
  wire wr_ctrl = wr && (i_wb_adr == ADDR_CTRL);
  wire [7:0] wbyte = i_wb_dat[7:0];
  wire in_msg = (msg_id == MSG_SYNC_CONFIG); // R2
  wire rec_last = wr_data && in_msg && (byte_idx == OFS_DELAY_HI);
  wire [15:0] rec_delay_full = {wbyte, rec_delay[7:0]};
  // R3
  wire rec_match = (rec_action == ACTION_SEND_LATEST) && (rec_line == LINE_SYNC_IN);
  wire apply_rec = rec_last && rec_match;
  // Status: delay running, armed, action count
  wire [31:0] status_word = {14'h0000, state == ST_DELAY, armed, action_count};
  wire [31:0] next_rdata = read_word(i_wb_adr, msg_id, byte_idx, event_count, status_word);

  // Edge qualification
  logic rise;
  logic fall;
  sync_edge_detect u_edge (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_sync_in),
    .o_rise(rise),
    .o_fall(fall)
  );
  wire edge_hit = edge_selected(cfg_edge, rise, fall); // R4
  wire event_ok = armed && edge_hit;
  wire skipping = (skip_cnt != 16'h0000);
  wire qualify = event_ok && !skipping; // R5 R6
  // One delay unit is a fixed number of clock cycles
  wire unit_tick = (cyc_cnt == 14'(DELAY_UNIT_CYCLES - 1));
  wire delay_done = (state == ST_DELAY) && ((units_left == 16'h0000) || (unit_tick && units_left == 16'h0001));

  // Bus handshake and read data
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack <= 1'b0;
      rdata <= RESET_WORD;
    end else begin
      ack <= req;
      if (req) begin
        rdata <= next_rdata;
      end
    end
  end
  assign o_wb_ack = ack;
  assign o_wb_dat = rdata;

  // Message intake: each 12-byte record walks through byte_idx
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      msg_id <= 8'h00;
      byte_idx <= 4'h0;
      rec_action <= 8'h00;
      rec_line <= 8'h00;
      rec_edge <= 8'h00;
      rec_skip_first <= 16'h0000;
      rec_skip_factor <= 16'h0000;
      rec_delay <= 16'h0000;
    end else if (wr_msg) begin
      msg_id <= wbyte;
      byte_idx <= 4'h0;
    end else if (wr_data && in_msg) begin
      byte_idx <= (byte_idx == 4'(RECORD_BYTES - 1)) ? 4'h0 : byte_idx + 4'h1; // R2
      case (byte_idx)
        OFS_ACTION: rec_action <= wbyte;
        OFS_LINE: rec_line <= wbyte;
        OFS_EDGE: rec_edge <= wbyte;
        OFS_SKIP_FIRST_LO: rec_skip_first[7:0] <= wbyte;
        OFS_SKIP_FIRST_HI: rec_skip_first[15:8] <= wbyte;
        OFS_SKIP_FACTOR_LO: rec_skip_factor[7:0] <= wbyte;
        OFS_SKIP_FACTOR_HI: rec_skip_factor[15:8] <= wbyte;
        OFS_DELAY_LO: rec_delay[7:0] <= wbyte;
        OFS_DELAY_HI: rec_delay[15:8] <= wbyte;
        default: ; // R8
      endcase
    end
  end

  // Apply a completed record; a control write of bit 0 disarms
  // Records for other actions or lines leave the active settings alone
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      armed <= 1'b0;
      cfg_edge <= 8'h00;
      cfg_skip_factor <= 16'h0000;
      cfg_delay <= 16'h0000;
    end else if (apply_rec) begin
      armed <= 1'b1; // R2
      cfg_edge <= rec_edge;
      cfg_skip_factor <= rec_skip_factor;
      cfg_delay <= clamp_delay(rec_delay_full); // R7
    end else if (wr_ctrl && wbyte[0]) begin
      armed <= 1'b0;
    end
  end

  // Skipping, delay and action: next values
  trig_state_t next_state;
  logic [15:0] next_skip_cnt;
  logic [15:0] next_units_left;
  logic [13:0] next_cyc_cnt;
  logic next_send;
  logic [15:0] next_action_count;
  logic [15:0] next_event_count;

  always_comb begin
    next_state = state;
    next_skip_cnt = skip_cnt;
    next_units_left = units_left;
    next_cyc_cnt = cyc_cnt;
    next_send = 1'b0;
    next_action_count = action_count;
    next_event_count = event_count;
    if (apply_rec) begin
      // A fresh record aborts a pending delay and restarts skipping
      next_state = ST_IDLE;
      next_skip_cnt = rec_skip_first; // R5
      next_units_left = 16'h0000;
      next_cyc_cnt = 14'h0000;
    end else begin
      if (event_ok) begin
        next_event_count = event_count + 16'h0001;
      end
      // Edges during a running delay do not count toward skipping
      if (event_ok && skipping && state == ST_IDLE) begin
        next_skip_cnt = skip_cnt - 16'h0001; // R5 R6
      end
      case (state)
        ST_IDLE: begin
          if (qualify) begin
            next_state = ST_DELAY;
            next_units_left = cfg_delay; // R7
            next_cyc_cnt = 14'h0000;
          end
        end
        ST_DELAY: begin
          next_cyc_cnt = unit_tick ? 14'h0000 : cyc_cnt + 14'h0001;
          if (unit_tick && units_left != 16'h0000) begin
            next_units_left = units_left - 16'h0001; // R7
          end
          if (delay_done) begin
            next_state = ST_IDLE;
            next_send = 1'b1; // R1
            next_skip_cnt = cfg_skip_factor; // R6
            next_action_count = action_count + 16'h0001;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // Registered trigger state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      skip_cnt <= 16'h0000;
      units_left <= 16'h0000;
      cyc_cnt <= 14'h0000;
      send_pulse <= 1'b0;
      action_count <= 16'h0000;
      event_count <= 16'h0000;
    end else begin
      state <= next_state;
      skip_cnt <= next_skip_cnt;
      units_left <= next_units_left;
      cyc_cnt <= next_cyc_cnt;
      send_pulse <= next_send;
      action_count <= next_action_count;
      event_count <= next_event_count;
    end
  end

  assign o_send_latest = send_pulse; // R1
endmodule
`default_nettype wire

// ===== tb/sync_trigger_assertions.sv
// Port-level checks for the sync-input trigger
`timescale 1ns/1ps
`default_nettype none
module sync_trigger_assertions
  import sync_trigger_pkg::*;
(
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  // Sync pin and action
  input wire logic i_sync_in,
  input wire logic o_send_latest
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic rd_req = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
  ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered in one cycle");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  send_pulse_a: assert property (o_send_latest |=> !o_send_latest)
    else $error("send request longer than one cycle");
  unmapped_zero_a: assert property (rd_req && i_wb_adr[1:0] != 2'b00 |=> o_wb_dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  status_width_a: assert property (rd_req && i_wb_adr == ADDR_STATUS |=> o_wb_dat[31:18] == 14'h0000)
    else $error("status upper bits set");
  count_width_a: assert property (rd_req && i_wb_adr == ADDR_CTRL |=> o_wb_dat[31:16] == 16'h0000)
    else $error("edge count upper bits set");
  byte_index_a: assert property (rd_req && i_wb_adr == ADDR_DATA |=> o_wb_dat[31:4] == 28'h000_0000)
    else $error("byte index upper bits set");
  reset_quiet_a: assert property ($rose(i_reset_n) |-> !o_send_latest && !o_wb_ack)
    else $error("output active right after reset");
  cover property (o_send_latest);
  cover property (rd_req ##1 o_wb_ack);
  cover property ($fell(i_sync_in));
endmodule
`default_nettype wire

// ===== tb/sync_source_model.sv
// Far-side sensor system that drives the sync input pin
`timescale 1ns/1ps
`default_nettype none
module sync_source_model (
  // Clock
  input wire logic i_clk,
  // Sync pin
  output logic o_sync
);
  initial o_sync = 1'b0;
  // One pulse, high for hi cycles then low for lo cycles
  task automatic pulse(input int hi, input int lo);
    @(posedge i_clk) o_sync <= 1'b1;
    repeat (hi) @(posedge i_clk);
    o_sync <= 1'b0;
    repeat (lo) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/sync_input_trigger_test.sv
// Self-checking bench for the sync-input trigger
`timescale 1ns/1ps
`default_nettype none
module sync_input_trigger_test;
  import sync_trigger_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  wire logic [31:0] rdat;
  wire logic ack, send, sync;
  int num_errors = 0, num_checks = 0, sends = 0, base;
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (send === 1'b1) sends <= sends + 1;
  sync_input_trigger dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat), .i_sync_in(sync),
    .o_send_latest(send));
  sync_source_model src (.i_clk(i_clk), .o_sync(sync));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
  endtask
  // Whole record; bytes 3, 8 and 9 carry junk that must be ignored
  task automatic cfg(input logic [7:0] act, line, esel, input logic [15:0] sf, sk, dl);
    logic [7:0] b [12];
    logic [31:0] q;
    b = '{act, line, esel, 8'hFF, sf[7:0], sf[15:8], sk[7:0], sk[15:8], 8'hFF, 8'hFF, dl[7:0], dl[15:8]};
    wb(1'b1, ADDR_MSG, {24'h00_0000, MSG_SYNC_CONFIG}, q);
    foreach (b[i]) wb(1'b1, ADDR_DATA, {24'h00_0000, b[i]}, q);
  endtask
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    wb(1'b0, ADDR_STATUS, 32'h0000_0000, q);
    chk(q, RESET_WORD);
    wb(1'b0, 4'h1, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    base = sends;
    cfg(8'h07, LINE_SYNC_IN, EDGE_RISING, 16'h0000, 16'h0000, 16'h0000);
    cfg(ACTION_SEND_LATEST, 8'h01, EDGE_RISING, 16'h0000, 16'h0000, 16'h0000);
    wb(1'b0, ADDR_MSG, 32'h0000_0000, q);
    chk(q, {24'h00_0000, MSG_SYNC_CONFIG});
    repeat (3) src.pulse(6, 12);
    chk(sends - base, 0);
    $display("test foreign records done");
    for (int e = 0; e < 4; e++) begin
      cfg(ACTION_SEND_LATEST, LINE_SYNC_IN, 8'(e), 16'h0000, 16'h0000, 16'h0000);
      base = sends;
      repeat (3) src.pulse(6, 12);
      chk(sends - base, (e == 3) ? 6 : ((e == 0) ? 0 : 3));
    end
    $display("test edge codes done");
    cfg(ACTION_SEND_LATEST, LINE_SYNC_IN, EDGE_RISING, 16'h0002, 16'h0001, 16'h0000);
    base = sends;
    repeat (8) src.pulse(6, 12);
    chk(sends - base, 3);
    $display("test skip counts done");
    cfg(ACTION_SEND_LATEST, LINE_SYNC_IN, EDGE_RISING, 16'h0000, 16'h0000, 16'h0001);
    base = sends;
    src.pulse(6, 12);
    src.pulse(6, 9900);
    chk(sends - base, 0);
    wb(1'b0, ADDR_STATUS, 32'h0000_0000, q);
    chk(q[17:16], 2'b11);
    repeat (100) @(posedge i_clk);
    chk(sends - base, 1);
    $display("test delay done");
    wb(1'b0, ADDR_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0016);
    wb(1'b0, ADDR_DATA, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    wb(1'b1, ADDR_CTRL, 32'h0000_0001, q);
    base = sends;
    repeat (2) src.pulse(6, 12);
    chk(sends - base, 0);
    wb(1'b0, ADDR_STATUS, 32'h0000_0000, q);
    chk(q[17:16], 2'b00);
    $display("test counters and disarm done");
    give_verdict();
  end
endmodule
bind sync_input_trigger sync_trigger_assertions chk_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_sync_in(i_sync_in), .o_send_latest(o_send_latest));
`default_nettype wire
